// ===== sim/sacs_props.sv
// Purpose: Concurrent checks on the converter link pins.
// Assumes: Both ends on one clock; chain input held steady by the host.
// Notes: Start is seen on the OR of the two select pins, as the device does.
`timescale 1ns/1ps
`default_nettype none
module sacs_props (
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic cs_n,
  input wire logic rc_n,
  input wire logic busy_n,
  input wire logic shift_clock_source,
  input wire logic power_down_in,
  input wire logic chain_in,
  input wire logic data,
  input wire logic frame_marker,
  input wire logic sck
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  logic or_q;
  logic sck_q;
  logic tag_q;
  logic [7:0] low_q;
  logic [4:0] fall_q;
  logic start_w;
  // ==========================================================================
  // Helper state
  // Pin-level start, before the device's own synchroniser
  assign start_w = or_q && !(cs_n | rc_n);
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      or_q <= 1'b1;
      sck_q <= 1'b0;
      low_q <= 8'h00;
    end else begin
      or_q <= cs_n | rc_n;
      sck_q <= sck;
      low_q <= busy_n ? 8'h00 : low_q + 8'h01;
    end
  end
  // Falls per frame; saturates so idle checks need no extra flag
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      fall_q <= 5'h00;
      tag_q <= 1'b0;
    end else if (start_w) begin
      fall_q <= 5'h00;
      tag_q <= chain_in;
    end else if (!shift_clock_source && sck_q && !sck && fall_q < 5'h10) begin
      fall_q <= fall_q + 5'h01;
    end
  end
  // ==========================================================================
  // Properties
  sequence s_start;
    start_w && busy_n && !power_down_in;
  endsequence
  sequence s_conv;
    ##[1:6] !busy_n;
  endsequence
  property p_start;
    s_start |-> s_conv;
  endproperty
  a_start_busy: assert property (p_start)
    else $error("busy did not fall after start");
  a_pd_refuse: assert property (start_w && busy_n && power_down_in |-> busy_n [*6])
    else $error("conversion started in power down");
  a_busy_len: assert property ($rose(busy_n) |-> low_q == 8'd48)
    else $error("busy low time wrong");
  a_pulse_count: assert property (!shift_clock_source && $fell(sck) |-> fall_q < 5'h10)
    else $error("more than 16 internal pulses");
  a_int_idle: assert property (!shift_clock_source && busy_n && fall_q == 5'h10
    && $stable(fall_q) |-> !sck && data == tag_q)
    else $error("internal idle sck or data wrong");
  a_bit_stable: assert property (!shift_clock_source && $changed(sck) |-> $stable(data))
    else $error("data moved on sck edge");
  a_frame_pulse: assert property ($rose(frame_marker) |=> !frame_marker)
    else $error("frame marker longer than one cycle");
  a_frame_mode: assert property (frame_marker |-> shift_clock_source)
    else $error("frame marker in internal mode");
endmodule // sacs_props
`default_nettype wire

// ===== sim/tb.sv
// Purpose: Bench for both converter link ends, driven over AHB-Lite.
// Assumes: Host and device share one 20 MHz clock.
// Notes: Two conversions per case, since internal mode sends the previous word.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk;
  logic rst;
  logic hsel;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [15:0] sh = 16'h0000;
  logic sck_d = 1'b0;
  int n_frame = 0;
  logic [31:0] rd;
  logic [15:0] codes [4] = '{16'h8000, 16'hffff, 16'h0001, 16'h7ffe};
  int n_fail;
  int n_tests;
  sacs_link_if link ();
  sacs_dev sacs_dev_inst (.MCLK_IN(mclk), .SYS_RST_IN(rst), .LINK(link.dev));
  sacs_host sacs_host_inst (.MCLK_IN(mclk), .SYS_RST_IN(rst), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
    .HWDATA_IN(hwdata), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .LINK(link.host));
  sacs_props sacs_props_inst (.MCLK_IN(mclk), .SYS_RST_IN(rst), .cs_n(link.cs_n),
    .rc_n(link.rc_n), .busy_n(link.busy_n), .shift_clock_source(link.shift_clock_source),
    .power_down_in(link.power_down_in), .chain_in(link.chain_in), .data(link.data),
    .frame_marker(link.frame_marker), .sck(link.sck));
  // ==========================================================================
  // Clock and wire monitor
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Data sampled on every shift clock rise, either source
  always @(posedge mclk) begin
    sck_d <= link.sck;
    if (link.sck && !sck_d) sh <= {sh[14:0], link.data};
    if (link.frame_marker) n_frame <= n_frame + 1;
  end
  // ==========================================================================
  // Bus and check tasks
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    d = hrdata;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h0, rd);
    check(nm, exp, rd);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask
  // Poll until both busy and the host sequence are clear
  task automatic wait_idle();
    int i;
    repeat (4) @(posedge mclk);
    for (i = 0; i < 400; i++) begin
      bus(1'b0, sacs_pkg::REG_STAT, 32'h0, rd);
      if (rd[1:0] === 2'b00) break;
    end
    check("idle", 32'h0, {30'h0, rd[1:0]});
  endtask
  task automatic conv(input logic [4:0] ctl, input logic [15:0] code);
    logic [15:0] exp;
    int nf;
    exp = ctl[1] ? code : code ^ 16'h8000;
    nf = n_frame;
    wr(sacs_pkg::REG_ANALOG, {16'h0, code});
    wr(sacs_pkg::REG_CTRL, {27'h0, ctl});
    repeat (2) begin
      wr(sacs_pkg::REG_CTRL, {27'h0, ctl | 5'h01});
      wait_idle();
    end
    // Margin for the data pin to settle after the last shift
    repeat (80) @(posedge mclk);
    rchk(sacs_pkg::REG_DATA, {16'h0, exp}, "result");
    check("serial", {16'h0, exp}, {16'h0, sh});
    check("frames", ctl[2] ? 32'd2 : 32'd0, n_frame - nf);
    check("idle data", {31'h0, ctl[4]}, {31'h0, link.data});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================================
  // Watchdog, well beyond the eight conversions
  initial begin
    #3000000;
    n_fail++;
    $display("ERROR watchdog expected done seen hang");
    conclude();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    n_fail = 0;
    n_tests = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rchk(sacs_pkg::REG_CTRL, sacs_pkg::CTRL_RST, "ctrl reset");
    rchk(sacs_pkg::REG_STAT, 32'h0, "stat reset");
    wr(8'h10, 32'hffff_ffff);
    rchk(8'h10, 32'h0, "unmapped");
    // Every format and clock source, boundary codes
    for (int i = 0; i < 4; i++) begin
      conv({i[0], 1'b0, i[1], i[0], 1'b0}, codes[i]);
    end
    // Power down: start refused, last word kept
    wr(sacs_pkg::REG_CTRL, 32'h0000_000e);
    wr(sacs_pkg::REG_CTRL, 32'h0000_000f);
    repeat (100) @(posedge mclk);
    check("busy pin", 32'h1, {31'h0, link.busy_n});
    rchk(sacs_pkg::REG_DATA, {16'h0, codes[3]}, "held result");
    conclude();
  end
endmodule // tb
`default_nettype wire

// ===== src/sacs_dev.sv
// Purpose: Digital control of a 16-bit SAR converter with serial output.
// Assumes: Analog comparator modelled by comparing against a sampled code.
// Notes: CS, RC and shift clock pins are synchronised to MCLK_IN; the other inputs are used directly.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - CS low: RC fall holds, starts conversion
// - CS low: RC rise enables serial output
// - RC low: CS fall starts conversion
// - RC high: CS fall enables serial output
// - Busy low while converting, high when valid
// - Both low at busy rise restarts
// - Start clears SAR; busy ignores starts
// - Format high binary, low twos complement
// - Binary is twos complement, MSB inverted
// - External mode shifts on host clock
// - Internal mode: start sends 16 pulses
// - Internal mode: clock low between conversions
// - Internal bit stable across both edges
// - Idle data holds chain level at start
// - External mode: one frame marker pulse
// - External: chain input follows 16 bits
// - Power down refuses starts, keeps result
// - Host returns RC high within 1.2us; the host holds RC low if power down refuses the start
// - Host finishes external shifting within 1.2us; the host shifts for 6.4us, starting after busy rises
module sacs_dev (
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  sacs_link_if.dev LINK
);
  typedef logic [sacs_pkg::CNT_W-1:0] sacs_cnt_t;
  typedef enum logic [1:0] {
    IDLE = 2'b01,
    CONV = 2'b10
  } sacs_cstate_t;

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] cs_s_q, rc_s_q, sck_s_q;
  logic cs_q, rc_q, sck_q;
  logic start_fall, read_edge, sck_rise, sck_fall;
  // Two stages per pin, then a third for edge detection
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      cs_s_q <= 2'b11;
      rc_s_q <= 2'b11;
      sck_s_q <= 2'b00;
      cs_q <= 1'b1;
      rc_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      cs_s_q <= {cs_s_q[0], LINK.cs_n};
      rc_s_q <= {rc_s_q[0], LINK.rc_n};
      sck_s_q <= {sck_s_q[0], LINK.sck};
      cs_q <= cs_s_q[1];
      rc_q <= rc_s_q[1];
      sck_q <= sck_s_q[1];
    end
  end
  // OR of the two selects; its fall starts, an RC rise with CS low or a CS fall with RC high reads
  assign start_fall = (cs_q | rc_q) & !(cs_s_q[1] | rc_s_q[1]);
  assign read_edge = (!cs_s_q[1] & !rc_q & rc_s_q[1])
    | (rc_s_q[1] & cs_q & !cs_s_q[1]);
  assign sck_rise = !sck_q & sck_s_q[1];
  assign sck_fall = sck_q & !sck_s_q[1];

  // ==========================================================================
  // Conversion engine
  sacs_cstate_t st_q;
  logic [15:0] sar_q, result_q, code_q;
  logic [4:0] bit_q;
  sacs_cnt_t step_q;
  logic both_low_q;
  logic start_ok;
  // Level check at busy rise lets a held-low pair restart without acquisition
  assign start_ok = (start_fall | (st_q == IDLE && both_low_q)) & !LINK.power_down_in;

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st_q <= IDLE;
      sar_q <= 16'h0000;
      code_q <= 16'h0000;
      result_q <= 16'h0000;
      bit_q <= 5'h00;
      step_q <= '0;
      both_low_q <= 1'b0;
    end else begin
      both_low_q <= 1'b0;
      unique case (st_q)
        IDLE: begin
          if (start_ok) begin
            st_q <= CONV;
            sar_q <= 16'h0000;
            code_q <= LINK.analog; // Sample held here
            bit_q <= 5'd15;
            step_q <= '0;
          end
        end
        CONV: begin
          // Further starts are not looked at while converting
          if (step_q == sacs_cnt_t'(sacs_pkg::CONV_STEP_CYC - 1)) begin
            step_q <= '0;
            // Trial bit kept when sample is at or above it
            if ((sar_q | (16'h0001 << bit_q)) <= code_q) begin
              sar_q <= sar_q | (16'h0001 << bit_q);
            end
            if (bit_q == 5'd0) begin
              result_q <= ((sar_q | 16'h0001) <= code_q) ? (sar_q | 16'h0001) : sar_q;
              st_q <= IDLE;
              both_low_q <= !cs_s_q[1] & !rc_s_q[1];
            end else begin
              bit_q <= bit_q - 5'd1; // MSB down to LSB
            end
          end else begin
            step_q <= step_q + sacs_cnt_t'(1);
          end
        end
      endcase
    end
  end
  // Result loaded on the same edge that this rises
  assign LINK.busy_n = (st_q == IDLE);

  // ==========================================================================
  // Output formatting
  function automatic logic [15:0] fmt(input logic [15:0] v, input logic sb);
    fmt = sb ? (v ^ sacs_pkg::MSB_FLIP) : v;
  endfunction

  // ==========================================================================
  // Serial shifter; analog code is offset binary, result kept as offset binary too
  logic [15:0] shreg_q;
  logic [4:0] cnt_q;
  logic tag_q, data_q, sck_o_q, isck_run_q, frame_q, ext_arm_q;
  sacs_cnt_t half_q;
  logic [15:0] outword;
  assign outword = fmt(result_q ^ sacs_pkg::MSB_FLIP, LINK.format_select);

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      shreg_q <= 16'h0000;
      cnt_q <= 5'h00;
      tag_q <= 1'b0;
      data_q <= 1'b0;
      sck_o_q <= 1'b0;
      isck_run_q <= 1'b0;
      half_q <= '0;
      frame_q <= 1'b0;
      ext_arm_q <= 1'b0;
    end else begin
      frame_q <= 1'b0;
      if (start_ok && st_q == IDLE) begin
        tag_q <= LINK.chain_in;
      end
      if (!LINK.shift_clock_source) begin
        ext_arm_q <= 1'b0;
        // Internal clock: previous result goes out during the conversion
        if (start_ok && st_q == IDLE) begin
          shreg_q <= outword;
          data_q <= outword[15];
          cnt_q <= 5'd16;
          isck_run_q <= 1'b1;
          half_q <= '0;
          sck_o_q <= 1'b0;
        end else if (isck_run_q) begin
          // High one cycle per period, so 16 pulses end inside the conversion
          sck_o_q <= (half_q == '0);
          if (half_q == sacs_cnt_t'(sacs_pkg::ISCK_PERIOD_CYC - 1)) begin
            half_q <= '0;
            // Bit moves a cycle after the fall, so stable at both edges
            shreg_q <= {shreg_q[14:0], tag_q};
            cnt_q <= cnt_q - 5'd1;
            data_q <= (cnt_q == 5'd1) ? tag_q : shreg_q[14];
            if (cnt_q == 5'd1) begin
              isck_run_q <= 1'b0; // Exactly 16 pulses
            end
          end else begin
            half_q <= half_q + sacs_cnt_t'(1);
          end
        end
      end else begin
        isck_run_q <= 1'b0;
        sck_o_q <= 1'b0;
        // Read enable arms a frame and sets the first bit; marker on next host clock
        if (read_edge) begin
          ext_arm_q <= 1'b1;
          shreg_q <= outword;
          data_q <= outword[15];
        end else if (ext_arm_q && sck_rise) begin
          ext_arm_q <= 1'b0;
          frame_q <= 1'b1;
        end else if (sck_fall && !cs_s_q[1] && rc_s_q[1]) begin
          // Chain input enters behind the result, 16 clocks late
          shreg_q <= {shreg_q[14:0], LINK.chain_in};
          data_q <= shreg_q[14];
        end
      end
    end
  end
  assign LINK.data = data_q;
  assign LINK.frame_marker = frame_q;
  assign LINK.sck_dev_o = sck_o_q;
  assign LINK.sck_dev_oe_n = LINK.shift_clock_source;
endmodule // sacs_dev
`default_nettype wire

// ===== src/sacs_host.sv
// Purpose: Host end: AHB-Lite registers drive conversions and collect data.
// Assumes: Single-word transfers, OKAY response only.
// Notes: Reads 16 bits per conversion, during it with internal clock, after busy rises with external clock.
`timescale 1ns/1ps
`default_nettype none
module sacs_host (
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic HSEL_IN,
  input wire logic [7:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  sacs_link_if.host LINK
);
  typedef logic [sacs_pkg::CNT_W-1:0] sacs_cnt_t;
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_CONV = 4'b0010,
    H_WAIT = 4'b0100,
    H_SHIFT = 4'b1000
  } sacs_hstate_t;

  // ==========================================================================
  // Bus slave: always ready, zero wait states
  logic wr_q;
  logic [7:0] addr_q;
  logic [31:0] ctrl_q, analog_q;
  logic [15:0] rx_q;
  logic [4:0] rcnt_q;
  sacs_hstate_t st_q;
  logic [1:0] busy_s_q, data_s_q, sck_s_q;
  logic busy_q, sck_q;
  sacs_cnt_t div_q;
  logic sck_o_q, start_w;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;
  assign start_w = wr_q && addr_q == sacs_pkg::REG_CTRL && HWDATA_IN[sacs_pkg::CTRL_START];

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      ctrl_q <= sacs_pkg::CTRL_RST;
      analog_q <= 32'h0000_0000;
    end else begin
      wr_q <= HSEL_IN && HTRANS_IN[1] && HWRITE_IN;
      addr_q <= HADDR_IN;
      if (wr_q && addr_q == sacs_pkg::REG_CTRL) begin
        ctrl_q <= {HWDATA_IN[31:1], 1'b0}; // Start bit self-clears
      end
      if (wr_q && addr_q == sacs_pkg::REG_ANALOG) begin
        analog_q <= {16'h0000, HWDATA_IN[15:0]};
      end
    end
  end
  // Read mux from the registered address phase
  always_comb begin
    unique case (addr_q)
      sacs_pkg::REG_CTRL: HRDATA_OUT = ctrl_q;
      sacs_pkg::REG_STAT: HRDATA_OUT = {30'h0, st_q != H_IDLE, !busy_q};
      sacs_pkg::REG_DATA: HRDATA_OUT = {16'h0000, rx_q};
      sacs_pkg::REG_ANALOG: HRDATA_OUT = analog_q;
      default: HRDATA_OUT = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Pin synchronisers
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      busy_s_q <= 2'b11;
      data_s_q <= 2'b00;
      sck_s_q <= 2'b00;
      busy_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      busy_s_q <= {busy_s_q[0], LINK.busy_n};
      data_s_q <= {data_s_q[0], LINK.data};
      sck_s_q <= {sck_s_q[0], LINK.sck};
      busy_q <= busy_s_q[1];
      sck_q <= sck_s_q[1];
    end
  end

  // ==========================================================================
  // Sequencer: pulse RC low, wait for busy, then read with chosen clock
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st_q <= H_IDLE;
      LINK.rc_n <= 1'b1;
      rx_q <= 16'h0000;
      rcnt_q <= 5'h00;
      div_q <= '0;
      sck_o_q <= 1'b0;
    end else begin
      unique case (st_q)
        H_IDLE: begin
          if (start_w) begin
            LINK.rc_n <= 1'b0;
            st_q <= H_CONV;
            rcnt_q <= 5'd16;
          end
        end
        H_CONV: begin
          // RC returned high once busy is seen low, well inside 1.2us; stays low if power down refuses the start
          if (!busy_q) begin
            LINK.rc_n <= 1'b1;
            st_q <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (busy_q) begin
            st_q <= ctrl_q[sacs_pkg::CTRL_EXT] ? H_SHIFT : H_IDLE;
            div_q <= '0;
          end
        end
        H_SHIFT: begin
          // External clock after conversion; 16 clocks after the marker
          // Never shifts while busy, so the 1.2us limit cannot be missed
          if (div_q == sacs_cnt_t'(sacs_pkg::ESCK_HALF_CYC - 1)) begin
            div_q <= '0;
            sck_o_q <= !sck_o_q;
            if (sck_o_q) begin
              rx_q <= {rx_q[14:0], data_s_q[1]};
              rcnt_q <= rcnt_q - 5'd1;
              if (rcnt_q == 5'd1) begin
                st_q <= H_IDLE;
              end
            end
          end else begin
            div_q <= div_q + sacs_cnt_t'(1);
          end
        end
      endcase
      // Internal mode: capture on device rises from start until busy seen high;
      // the first rise comes before the host has seen busy fall
      if ((st_q == H_CONV || st_q == H_WAIT) && !ctrl_q[sacs_pkg::CTRL_EXT] && !sck_q
          && sck_s_q[1] && rcnt_q != 5'd0) begin
        rx_q <= {rx_q[14:0], data_s_q[1]};
        rcnt_q <= rcnt_q - 5'd1; // 16 bits, MSB first
      end
    end
  end
  assign LINK.cs_n = 1'b0;
  assign LINK.format_select = ctrl_q[sacs_pkg::CTRL_FMT];
  assign LINK.shift_clock_source = ctrl_q[sacs_pkg::CTRL_EXT];
  assign LINK.power_down_in = ctrl_q[sacs_pkg::CTRL_PD];
  assign LINK.chain_in = ctrl_q[sacs_pkg::CTRL_TAG];
  assign LINK.analog = analog_q[15:0];
  assign LINK.sck_host_o = sck_o_q;
  assign LINK.sck_host_oe_n = !ctrl_q[sacs_pkg::CTRL_EXT];
endmodule // sacs_host
`default_nettype wire

// ===== src/sacs_link_if.sv
// Purpose: Pins between the converter control and its host.
// Assumes: Shift clock pin is two-way; enables are active low.
// Notes: The resolved wire level is worked out here.
`timescale 1ns/1ps
`default_nettype none
interface sacs_link_if;
  logic cs_n;
  logic rc_n;
  logic busy_n;
  logic format_select;
  logic shift_clock_source;
  logic power_down_in;
  logic chain_in;
  logic data;
  logic frame_marker;
  logic sck_dev_o;
  logic sck_dev_oe_n;
  logic sck_host_o;
  logic sck_host_oe_n;
  logic [15:0] analog;
  logic sck;
  // ==========================================================================
  // Wire resolution, low when nobody drives
  assign sck = !sck_dev_oe_n ? sck_dev_o : (!sck_host_oe_n ? sck_host_o : 1'b0);
  modport dev (input cs_n, rc_n, format_select, shift_clock_source, power_down_in,
    chain_in, analog, sck, output busy_n, data, frame_marker, sck_dev_o, sck_dev_oe_n);
  modport host (output cs_n, rc_n, format_select, shift_clock_source, power_down_in,
    chain_in, analog, sck_host_o, sck_host_oe_n, input busy_n, data, frame_marker, sck);
endinterface
`default_nettype wire

// ===== src/sacs_pkg.sv
// Purpose: Shared constants for the SAR converter control and its host end.
// Assumes: 20 MHz system clock on both ends.
// Notes: Timing counts are derived from times in ns.
package sacs_pkg;
  // ==========================================================================
  // Sizes and timing
  localparam int RES_BITS = 16;
  localparam int CLK_NS = 50;
  localparam int CONV_STEP_NS = 150;
  localparam int CONV_STEP_CYC = (CONV_STEP_NS + CLK_NS - 1) / CLK_NS;
  // Internal shift clock: one cycle high, rest low; needs at least 3 cycles
  localparam int ISCK_PERIOD_NS = 150;
  localparam int ISCK_PERIOD_CYC = (ISCK_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int ESCK_HALF_NS = 200;
  localparam int ESCK_HALF_CYC = (ESCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  localparam logic [15:0] MSB_FLIP = 16'h8000;
  // ==========================================================================
  // Host register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_ANALOG = 8'h0c;
  localparam int CTRL_START = 0;
  localparam int CTRL_FMT = 1;
  localparam int CTRL_EXT = 2;
  localparam int CTRL_PD = 3;
  localparam int CTRL_TAG = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_RUN = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
endpackage
